// >>> common/boot_pkg.sv
// constants, types and register map shared by the boot loader files
`default_nettype none
package boot_pkg;

    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned US_PER_S          = 1_000_000;
    // least delay from reset release to boot, in microseconds
    localparam int unsigned BOOT_DELAY_MIN_US = 15;
    localparam int unsigned BOOT_DELAY_MAX_US = 150;
    localparam int unsigned BOOT_DELAY_RAW    =
        (BOOT_DELAY_MIN_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
    localparam int unsigned BOOT_DELAY_CYCLES = (BOOT_DELAY_RAW < 1) ? 1 : BOOT_DELAY_RAW;
    localparam int unsigned DELAY_W           = 10;

    localparam logic [31:0] CRC_POLY          = 32'hEDB88320;
    localparam logic [31:0] CRC_PRESET        = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_SKIP_MAGIC    = 32'h0D15AB1E;

    localparam int unsigned SECURE_BOOT_BIT   = 5;
    localparam logic [31:0] SECURITY_RESET    = 32'h0000_0000;

    localparam int unsigned IMG_ADDR_W        = 24;
    localparam logic [23:0] OTP_IMAGE_BASE    = 24'h00_0000;
    localparam logic [23:0] FLASH_IMAGE_BASE  = 24'h00_0000;
    localparam int unsigned RAM_ADDR_W        = 16;
    localparam logic [15:0] RAM_BASE          = 16'h0000;

    // register byte offsets on the bus
    localparam logic [7:0] REG_PLL_CFG        = 8'h00;
    localparam logic [7:0] REG_STATUS         = 8'h04;
    localparam logic [7:0] REG_SECURITY       = 8'h08;
    localparam logic [7:0] REG_CRC            = 8'h0C;
    localparam logic [7:0] REG_LENGTH         = 8'h10;

    // field positions in the clock-multiplier register
    localparam int unsigned PLL_R_LSB         = 0;
    localparam int unsigned PLL_F_LSB         = 8;
    localparam int unsigned PLL_OD_LSB        = 24;

    typedef struct packed {
        logic [2:0]  output_divider;
        logic [11:0] feedback;
        logic [5:0]  inputDivider;
    } pll_cfg_s;

    localparam pll_cfg_s PLL_RATIO_40 = '{3'h1, 12'h09F, 6'h00};
    localparam pll_cfg_s PLL_RATIO_16 = '{3'h1, 12'h03F, 6'h00};
    localparam pll_cfg_s PLL_RATIO_8  = '{3'h1, 12'h01F, 6'h00};
    localparam pll_cfg_s PLL_RATIO_4  = '{3'h1, 12'h00F, 6'h00};

    typedef struct packed {
        logic secureBoot;
        logic crcSkipped;
        logic crcBad;
        logic halted;
        logic running;
    } boot_status_s;

    typedef enum logic [7:0] {
        ST_DELAY  = 8'h01,
        ST_LEN    = 8'h02,
        ST_PROG   = 8'h04,
        ST_CHECK  = 8'h08,
        ST_VERIFY = 8'h10,
        ST_RUN    = 8'h20,
        ST_HALT   = 8'h40
    } boot_state_e;

endpackage : boot_pkg
`default_nettype wire

// >>> dv/image_source_model.sv
// image source model: serves boot image bytes for the flash and the otp
`default_nettype none
module image_source_model
(
    input  wire logic        core_clk,
    input  wire logic        fetchReq,
    input  wire logic        fetchFromOtp,
    input  wire logic [23:0] fetchAddr,
    input  wire logic        slow,
    output var  logic        fetchValid,
    output logic      [7:0]  fetchByte
);
    timeunit 1ns;
    timeprecision 1ns;
    // slot 0 flash, slot 1 otp; the bench loads both before each boot
    logic [7:0] img[2][256];
    logic [7:0] lastByte = 8'h00;
    logic       phase = 1'b0;
    // unknown until the first edge; the loader ignores it while its request is low
    always @(posedge core_clk)
    begin
        phase <= ~phase;
        fetchValid <= fetchReq && (!slow || phase);
        if (fetchValid && fetchReq)
            lastByte <= fetchByte;
    end
    // nothing on offer: inverse of last byte, so a stale sample never matches
    assign fetchByte = fetchValid ? img[fetchFromOtp][fetchAddr[7:0]] : ~lastByte;
endmodule : image_source_model
`default_nettype wire

// >>> dv/reset_pll_and_boot_loader_bench.sv
// self-checking bench: boots images through the loader and pokes its registers
`default_nettype none
module reset_pll_and_boot_loader_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import boot_pkg::*;
    localparam int unsigned DLY = 8;
    logic core_clk, arst_n, ratio_select_lo, ratio_select_hi, wb_cyc_i, wb_stb_i, wb_we_i;
    logic wb_ack_o, fetchReq, fetchFromOtp, fetchValid, ramWe, tileResetN, gpioPullDownEn, slow;
    logic [31:0] securityWord, wb_dat_i, wb_dat_o, ramWdata, rd, lastCrc;
    logic [23:0] fetchAddr;
    logic [15:0] ramAddr, execStartAddr;
    logic [7:0]  wb_adr_i, fetchByte;
    logic [3:0]  wb_sel_i;
    pll_cfg_s    pllCfg;
    logic [31:0] ramSeen[$], expWords[$];
    logic [11:0] fbTab[4] = '{12'h09F, 12'h00F, 12'h01F, 12'h03F};
    int          num_errors, checked;

    reset_pll_and_boot_loader #(.DELAY_CYCLES(DLY)) reset_pll_and_boot_loader_inst (
        .core_clk, .arst_n, .ratio_select_lo, .ratio_select_hi, .securityWord, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetchReq,
        .fetchFromOtp, .fetchAddr, .fetchValid, .fetchByte, .ramWe, .ramAddr, .ramWdata,
        .tileResetN, .gpioPullDownEn, .execStartAddr, .pllCfg);
    image_source_model image_source_model_inst (.core_clk, .fetchReq, .fetchFromOtp,
        .fetchAddr, .slow, .fetchValid, .fetchByte);

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (ramWe === 1'b1)
            ramSeen.push_back(ramWdata);
    end
    //////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        cmp("bus ack", 32'h1, {31'h0, wb_ack_o});
        if (wb_ack_o !== 1'b1)
            close_out();
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask : wb
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (fetchReq !== lvl)
        begin
            @(posedge core_clk);
            n++;
            if (n > 3000)
            begin
                cmp("fetch request", {31'h0, lvl}, {31'h0, fetchReq});
                close_out();
            end
        end
    endtask : wait_req
    // kind: 0 good crc, 1 wrong crc, 2 skip word; the unused slot holds junk
    task automatic boot(input logic [1:0] straps, input logic sec, input int len,
                        input logic [1:0] kind, input logic slowMode);
        logic [31:0] w[$];
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        arst_n <= 1'b0;
        {ratio_select_hi, ratio_select_lo} <= straps;
        securityWord <= {26'h0, sec, 5'h00};
        slow <= slowMode;
        ramSeen.delete();
        expWords.delete();
        w.push_back(len);
        for (int j = 0; j < len; j++)
            w.push_back(32'hC45A_3E10 + j);
        for (int j = 1; j <= len; j++)
            expWords.push_back(w[j]);
        foreach (w[j])
            for (int b = 0; b < 4; b++)
                for (int k = 0; k < 8; k++)
                    c = ((c ^ {24'h0, w[j][8*b +: 8]} >> k) & 32'h1) ? (c >> 1) ^ 32'hEDB88320
                        : c >> 1;
        lastCrc = ~c;
        w.push_back(kind == 2'd2 ? 32'h0D15AB1E : (kind == 2'd1 ? c : ~c));
        for (int i = 0; i < 256; i++)
            image_source_model_inst.img[0][i] = 8'hC3;
        image_source_model_inst.img[1] = image_source_model_inst.img[0];
        foreach (w[j])
            for (int b = 0; b < 4; b++)
                image_source_model_inst.img[sec][4*j+b] = w[j][8*b +: 8];
        repeat (8) @(posedge core_clk);
        cmp("pull-down in reset", 32'h1, {31'h0, gpioPullDownEn});
        cmp("tile held in reset", 32'h0, {31'h0, tileResetN});
        arst_n <= 1'b1;
        wait_req(1'b1);
        cmp("pull-down after reset", 32'h0, {31'h0, gpioPullDownEn});
        wait_req(1'b0);
        repeat (4) @(posedge core_clk);
    endtask : boot
    //////////////////////////////////////////////////
    initial
    begin
        num_errors = 0;
        checked = 0;
        // reset is first applied on a clock edge so no reset event is lost at time zero
        arst_n = 1'b1;
        {ratio_select_hi, ratio_select_lo, slow} = 3'b000;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
        securityWord = 32'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        @(posedge core_clk);
        for (int s = 0; s < 4; s++)
        begin
            boot(s[1:0], 1'b0, 0, 2'd2, 1'b0);
            cmp("strap config", {11'h0, 3'h1, fbTab[s], 6'h00}, {11'h0, pllCfg});
            wb(1'b0, REG_STATUS, 4'hF, 32'h0, rd);
            cmp("skip status", 32'h0409, {19'h0, rd[12:0]});
            $display("test straps %0d done", s);
        end
        boot(2'b11, 1'b0, 3, 2'd0, 1'b1);
        cmp("word count", expWords.size(), ramSeen.size());
        foreach (expWords[j])
            cmp("ram word", expWords[j], ramSeen[j]);
        wb(1'b0, REG_CRC, 4'hF, 32'h0, rd);
        cmp("crc value", lastCrc, rd);
        wb(1'b0, REG_LENGTH, 4'hF, 32'h0, rd);
        cmp("length word", 32'h3, rd);
        wb(1'b0, REG_STATUS, 4'hF, 32'h0, rd);
        cmp("flash status", 32'h0401, {19'h0, rd[12:0]});
        $display("test flash boot done");
        boot(2'b00, 1'b1, 2, 2'd0, 1'b0);
        wb(1'b0, REG_STATUS, 4'hF, 32'h0, rd);
        cmp("otp status", 32'h0411, {19'h0, rd[12:0]});
        wb(1'b0, REG_SECURITY, 4'hF, 32'h0, rd);
        cmp("security word", 32'h0000_0020, rd);
        $display("test otp boot done");
        boot(2'b01, 1'b0, 2, 2'd1, 1'b1);
        repeat (20) @(posedge core_clk);
        cmp("bad crc halts", 32'h0, {31'h0, tileResetN});
        wb(1'b0, REG_STATUS, 4'hF, 32'h0, rd);
        cmp("halt status", 32'h0806, {19'h0, rd[12:0]});
        $display("test bad crc done");
        // only the byte lanes selected by wb_sel_i are written
        wb(1'b1, REG_PLL_CFG, 4'hF, 32'h0203_0405, rd);
        wb(1'b1, REG_PLL_CFG, 4'h1, 32'hFFFF_FF11, rd);
        cmp("pll port", {11'h0, 3'h2, 12'h304, 6'h11}, {11'h0, pllCfg});
        wb(1'b0, REG_PLL_CFG, 4'hF, 32'h0, rd);
        cmp("pll readback", 32'h0203_0411, rd);
        wb(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF, rd);
        wb(1'b0, 8'h20, 4'hF, 32'h0, rd);
        cmp("unmapped read", 32'h0, rd);
        $display("test registers done");
        close_out();
    end
endmodule : reset_pll_and_boot_loader_bench

bind reset_pll_and_boot_loader reset_pll_and_boot_loader_properties
    #(.DELAY_CYCLES(DELAY_CYCLES)) reset_pll_and_boot_loader_properties_inst (.core_clk,
    .arst_n, .ratio_select_lo, .ratio_select_hi, .securityWord, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .fetchReq, .fetchValid, .fetchFromOtp, .fetchAddr, .ramWe, .ramAddr,
    .tileResetN, .gpioPullDownEn, .execStartAddr, .pllCfg);
`default_nettype wire

// >>> dv/reset_pll_and_boot_loader_properties.sv
// port assertions for the reset, clock-ratio and boot loader block
`default_nettype none
module reset_pll_and_boot_loader_properties
    import boot_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = BOOT_DELAY_CYCLES
)
(
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        ratio_select_lo,
    input wire logic        ratio_select_hi,
    input wire logic [31:0] securityWord,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        fetchReq,
    input wire logic        fetchValid,
    input wire logic        fetchFromOtp,
    input wire logic [23:0] fetchAddr,
    input wire logic        ramWe,
    input wire logic [15:0] ramAddr,
    input wire logic        tileResetN,
    input wire logic        gpioPullDownEn,
    input wire logic [15:0] execStartAddr,
    input wire pll_cfg_s    pllCfg
);
    logic [31:0] sinceRel;
    logic [15:0] words;
    logic [11:0] strapFb;
    //////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sinceRel <= 32'h0;
        else
            sinceRel <= sinceRel + 32'h1;
    end
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            words <= 16'h0;
        else
            words <= words + {15'h0, ramWe};
    end
    assign strapFb = ratio_select_hi ? (ratio_select_lo ? 12'h03F : 12'h01F)
                                     : (ratio_select_lo ? 12'h00F : 12'h09F);
    //////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // reset is the cause here, so this one must stay live during it
    reset_hold_a: assert property (disable iff (1'b0)
        !arst_n |-> !tileResetN && gpioPullDownEn) else $error("tile not held in reset");
    pulldown_off_a: assert property ($past(arst_n) |-> !gpioPullDownEn)
        else $error("pull-downs left on after reset");
    boot_delay_a: assert property (fetchReq |-> sinceRel >= DELAY_CYCLES - 1)
        else $error("boot fetch began too early");
    boot_start_a: assert property (sinceRel == DELAY_CYCLES + 1 |->
        fetchReq && pllCfg == {3'h1, strapFb, 6'h00}) else $error("boot start or ratio wrong");
    boot_source_a: assert property ($rose(fetchReq) |-> fetchAddr == 24'h0 &&
        fetchFromOtp == securityWord[SECURE_BOOT_BIT]) else $error("wrong boot source");
    fetch_step_a: assert property (fetchReq && fetchValid |=>
        !fetchReq || fetchAddr == $past(fetchAddr) + 24'h1) else $error("fetch address skip");
    ram_order_a: assert property (ramWe |-> ramAddr == words && !tileResetN)
        else $error("program word misplaced");
    run_latch_a: assert property (tileResetN |->
        (!fetchReq && execStartAddr == 16'h0) ##1 tileResetN) else $error("run state broken");
    wb_answer_a: assert property (taken_s |=> ack_pulse_s)
        else $error("bus ack not one cycle");
endmodule : reset_pll_and_boot_loader_properties
`default_nettype wire

// >>> rtl/crc32_engine.sv
// reflected crc-32 register advanced one byte per accepted input
`default_nettype none
module crc32_engine
    import boot_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        clear,
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteIn,
    output logic      [31:0] crcState
);

    logic [31:0] next_crc;

    // lsb-first shift, one step per data bit
    always_comb
    begin
        next_crc = crcState;
        for (int i = 0; i < 8; i++)
        begin
            if (next_crc[0] ^ byteIn[i])
                next_crc = (next_crc >> 1) ^ CRC_POLY;
            else
                next_crc = next_crc >> 1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            crcState <= CRC_PRESET;
        else if (clear)
            crcState <= CRC_PRESET;
        else if (byteValid)
            crcState <= next_crc;
    end

endmodule : crc32_engine
`default_nettype wire

// >>> rtl/reset_pll_and_boot_loader.sv
// reset sequencing, clock-ratio straps and boot image loader of one tile
`default_nettype none
module reset_pll_and_boot_loader
    import boot_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = BOOT_DELAY_CYCLES
)
(
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    // strap pins
    input  wire logic                    ratio_select_lo,
    input  wire logic                    ratio_select_hi,
    // security word loaded from otp at power-up
    input  wire logic [31:0]             securityWord,
    // classic wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // image byte source
    output logic                         fetchReq,
    output logic                         fetchFromOtp,
    output logic      [IMG_ADDR_W-1:0]   fetchAddr,
    input  wire logic                    fetchValid,
    input  wire logic [7:0]              fetchByte,
    // ram write port
    output logic                         ramWe,
    output logic      [RAM_ADDR_W-1:0]   ramAddr,
    output logic      [31:0]             ramWdata,
    // tile control
    output logic                         tileResetN,
    output logic                         gpioPullDownEn,
    output logic      [RAM_ADDR_W-1:0]   execStartAddr,
    output pll_cfg_s                     pllCfg
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    boot_state_e           state;
    logic [DELAY_W-1:0]    delayCount;
    logic [1:0]            strapMeta;
    logic [1:0]            strapSync;
    logic [31:0]           securityReg;
    logic [1:0]            byteIdx;
    logic [31:0]           wordShift;
    logic [31:0]           progLength;
    logic [31:0]           wordsLeft;
    logic [31:0]           checkWord;
    logic [31:0]           crcState;
    logic                  crcClear;
    logic                  crcFeed;
    logic                  wordDone;
    logic [31:0]           wordNow;
    logic                  delayDone;
    boot_status_s          status;
    logic                  wbHit;
    logic [31:0]           next_rdata;
    pll_cfg_s              strapCfg;

    assign wbHit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wordNow   = {fetchByte, wordShift[31:8]};
    assign wordDone  = fetchValid & fetchReq & (byteIdx == 2'h3);
    assign delayDone = (state == ST_DELAY) && (delayCount == DELAY_W'(DELAY_CYCLES - 1));
    // the check word never enters the crc
    assign crcFeed   = fetchValid & fetchReq & ((state == ST_LEN) | (state == ST_PROG));
    assign crcClear  = delayDone;

    ////////////////////////////////////////////////////////////////////////////
    // strap synchroniser; straps are assumed static so one capture suffices

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
        end
        else
        begin
            strapMeta <= {ratio_select_hi, ratio_select_lo};
            strapSync <= strapMeta;
        end
    end

    always_comb
    begin
        case (strapSync)
            2'b00:   strapCfg = PLL_RATIO_40;
            2'b11:   strapCfg = PLL_RATIO_16;
            2'b10:   strapCfg = PLL_RATIO_8;
            2'b01:   strapCfg = PLL_RATIO_4;
            default: strapCfg = PLL_RATIO_40;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset outputs

    // pull-downs and tile reset assert asynchronously with the chip reset
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            gpioPullDownEn <= 1'b1;
        else
            gpioPullDownEn <= 1'b0;
    end

    // tile leaves reset only when a program is started after a crc match or the skip word
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            tileResetN <= 1'b0;
        else
            tileResetN <= (state == ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // post-release delay counter

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            delayCount <= '0;
        else if ((state == ST_DELAY) && !delayDone)
            delayCount <= delayCount + DELAY_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // security word captured once the delay ends, well after release

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            securityReg <= SECURITY_RESET;
        else if (delayDone)
            securityReg <= securityWord;
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock multiplier configuration

    // software may load values outside the legal ranges; nothing clamps them
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            pllCfg <= PLL_RATIO_40;
        else if (delayDone)
            pllCfg <= strapCfg;
        else if (wbHit && wb_we_i && (wb_adr_i == REG_PLL_CFG))
        begin
            if (wb_sel_i[0])
                pllCfg.inputDivider <= wb_dat_i[PLL_R_LSB +: 6];
            if (wb_sel_i[1])
                pllCfg.feedback[7:0] <= wb_dat_i[PLL_F_LSB +: 8];
            if (wb_sel_i[2])
                pllCfg.feedback[11:8] <= wb_dat_i[PLL_F_LSB + 8 +: 4];
            if (wb_sel_i[3])
                pllCfg.output_divider <= wb_dat_i[PLL_OD_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // boot sequencer

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= ST_DELAY;
        else
        begin
            case (state)
                ST_DELAY:
                    if (delayDone)
                        state <= ST_LEN;
                ST_LEN:
                    if (wordDone)
                        state <= (wordNow == 32'h0) ? ST_CHECK : ST_PROG;
                ST_PROG:
                    if (wordDone && (wordsLeft == 32'h1))
                        state <= ST_CHECK;
                ST_CHECK:
                    if (wordDone)
                        state <= ST_VERIFY;
                ST_VERIFY:
                    if ((checkWord == CRC_SKIP_MAGIC) || (checkWord == ~crcState))
                        state <= ST_RUN;
                    else
                        state <= ST_HALT;
                ST_RUN:
                    state <= ST_RUN;
                ST_HALT:
                    state <= ST_HALT;
                default:
                    state <= ST_HALT;
            endcase
        end
    end

    // byte assembly, least significant byte first
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            byteIdx   <= 2'h0;
            wordShift <= 32'h0;
        end
        else if (fetchValid && fetchReq)
        begin
            byteIdx   <= byteIdx + 2'h1;
            wordShift <= wordNow;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            progLength <= 32'h0;
            wordsLeft  <= 32'h0;
        end
        else if (wordDone && (state == ST_LEN))
        begin
            progLength <= wordNow;
            wordsLeft  <= wordNow;
        end
        else if (wordDone && (state == ST_PROG))
            wordsLeft <= wordsLeft - 32'h1;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            checkWord <= 32'h0;
        else if (wordDone && (state == ST_CHECK))
            checkWord <= wordNow;
    end

    ////////////////////////////////////////////////////////////////////////////
    // image fetch port: request held until the last check byte is taken

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fetchReq     <= 1'b0;
            fetchFromOtp <= 1'b0;
            fetchAddr    <= '0;
        end
        else if (delayDone)
        begin
            fetchReq     <= 1'b1;
            fetchFromOtp <= securityWord[SECURE_BOOT_BIT];
            fetchAddr    <= securityWord[SECURE_BOOT_BIT] ? OTP_IMAGE_BASE
                                                          : FLASH_IMAGE_BASE;
        end
        else if (fetchValid && fetchReq)
        begin
            fetchAddr <= fetchAddr + IMG_ADDR_W'(1);
            if (wordDone && (state == ST_CHECK))
                fetchReq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ram loading from the bottom upward

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ramWe    <= 1'b0;
            ramWdata <= 32'h0;
        end
        else
        begin
            ramWe    <= wordDone && (state == ST_PROG);
            ramWdata <= wordNow;
        end
    end

    // address advances after each write, so the first word lands at the base
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            ramAddr <= RAM_BASE;
        else if (ramWe)
            ramAddr <= ramAddr + RAM_ADDR_W'(1);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            execStartAddr <= RAM_BASE;
        else
            execStartAddr <= RAM_BASE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // crc over length word and program bytes

    crc32_engine u_crc
    (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .clear     (crcClear),
        .byteValid (crcFeed),
        .byteIn    (fetchByte),
        .crcState  (crcState)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status and register reads

    always_comb
    begin
        status.secureBoot = fetchFromOtp;
        status.crcSkipped = (state == ST_RUN) && (checkWord == CRC_SKIP_MAGIC);
        status.crcBad     = (state == ST_HALT);
        status.halted     = (state == ST_HALT);
        status.running    = (state == ST_RUN);
    end

    always_comb
    begin
        case (wb_adr_i)
            REG_PLL_CFG:
                next_rdata = {5'h00, pllCfg.output_divider, 4'h0, pllCfg.feedback,
                              2'h0, pllCfg.inputDivider};
            REG_STATUS:   next_rdata = {19'h0, state, status};
            REG_SECURITY: next_rdata = securityReg;
            REG_CRC:      next_rdata = ~crcState;
            REG_LENGTH:   next_rdata = progLength;
            default:      next_rdata = 32'h0;
        endcase
    end

    // one-cycle answer; unmapped addresses read zero and ignore writes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wbHit;
            wb_dat_o <= wbHit ? next_rdata : 32'h0;
        end
    end

endmodule : reset_pll_and_boot_loader
`default_nettype wire
